// *** rf_tx_serial_host_port.sv ***
// Serial host port, mode control and transmit data path of the transmitter
`timescale 1ns/1ps
// Function
// - Select rising in powerdown wakes oscillator; clock output runs once crystal is up
// - Select falling returns the serial engine to its initial state
// - Select held low for the hold-off time forces powerdown
// - With amplifier mode flag set, select falling latches the data pin
// - Sample input on serial clock fall, change output on serial clock rise
// - Three-wire uses data pin both ways; four-wire uses it for input only
// - Four-wire read data leaves on the auxiliary test pin
// - Interface select: 00 3-wire, 01 4-wire, 10 3-wire with aux data, 11 invalid
// - Command is two bits then a six-bit address
// - Write follows with data bytes; read shifts register contents out
// - Codes: 00 read, 01 write, 10 unsupported, 11 transmit with six flags
// - Burst transfers increment the register address after each byte
// - Write transfers XOR command byte and data bytes into checksum
// - Checksum clears on powerdown entry and on any write to it
// - Transmit command honoured only in PLL-standby
// - First flag: 0 asynchronous, 1 synchronous bit-rate latching
// - Second flag: select fall stops amplifier or latches data
// - Third flag: 0 NRZ, 1 Manchester, Manchester only with synchronous
// - Transmit data comes from data pin unless aux pin is selected
// - A detected failure switches the power amplifier off
// - Fourth flag picks amplitude-modulation setting set
// - Last two flags pick frequency channel one to four
// - Serial clock rise after transmit command starts the amplifier
// - Register writes ignored while transmitter active
module rf_tx_serial_host_port #(
  parameter int PD_HOLD_CYCLES = rf_tx_pkg::PD_HOLD_CYC,
  parameter int XTAL_START_CYCLES = rf_tx_pkg::XTAL_START_CYC,
  parameter int BITRATE_HALF_CYCLES = rf_tx_pkg::BITRATE_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sel_pin,
  input wire logic sck_pin,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  input wire logic aux_test_pin_i,
  output logic aux_test_pin_o,
  output logic aux_test_pin_oe,
  input wire logic fail_detect,
  output logic clock_output_pin,
  output rf_tx_pkg::mode_t mode,
  output logic pa_enable,
  output logic mod_data,
  output rf_tx_pkg::tx_cfg_t tx_cfg
);

  localparam int PDW = $clog2(PD_HOLD_CYCLES + 1);
  localparam int XW = $clog2(XTAL_START_CYCLES + 1);
  localparam int BW = $clog2(BITRATE_HALF_CYCLES + 1);
  localparam int CW = $clog2(rf_tx_pkg::CLKOUT_HALF_CYC + 1);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic sel_d_q;
  logic sck_d_q;
  logic sel_s;
  logic sck_s;
  logic sdi_s;
  logic aux_s;
  logic sel_rise;
  logic sel_fall;
  logic sck_rise;
  logic sck_fall;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else if (ce) begin
      pin_s1_q <= {aux_test_pin_i, sdio_i, sck_pin, sel_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign sel_s = pin_s2_q[0];
  assign sck_s = pin_s2_q[1];
  assign sdi_s = pin_s2_q[2];
  assign aux_s = pin_s2_q[3];

  // Delayed copies for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_d_q <= 1'b0;
      sck_d_q <= 1'b0;
    end else if (ce) begin
      sel_d_q <= sel_s;
      sck_d_q <= sck_s;
    end
  end

  assign sel_rise = sel_s & ~sel_d_q;
  assign sel_fall = ~sel_s & sel_d_q;
  assign sck_rise = sck_s & ~sck_d_q & sel_s;
  assign sck_fall = ~sck_s & sck_d_q & sel_s;

  // ****************************************************
  // Serial engine
  // ****************************************************
  rf_tx_pkg::phase_t phase_q;
  rf_tx_pkg::ctrl_t ctrl_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] in_shift_q;
  logic [7:0] out_shift_q;
  logic [5:0] addr_q;
  logic [7:0] csum_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic wr_en;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;
  logic tx_cmd_ok;

  // Completed byte, MSB first
  assign rx_byte = {in_shift_q[6:0], sdi_s};
  assign byte_done = sck_fall && (bit_cnt_q == 3'h7);
  // Writes dropped while transmitting
  assign wr_en = byte_done && (phase_q == rf_tx_pkg::PH_WRITE)
      && (mode != rf_tx_pkg::MODE_TX_ACTIVE);
  assign tx_cmd_ok = (mode == rf_tx_pkg::MODE_PLL_STANDBY);

  // Bit counter and phase; select fall reinitialises all but the address
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= rf_tx_pkg::PH_CMD;
      bit_cnt_q <= 3'h0;
      in_shift_q <= 8'h00;
      addr_q <= 6'h00;
    end else if (ce) begin
      if (sel_fall || !sel_s) begin
        phase_q <= rf_tx_pkg::PH_CMD;
        bit_cnt_q <= 3'h0;
        in_shift_q <= 8'h00;
      end else if (sck_fall) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        in_shift_q <= rx_byte;
        if (bit_cnt_q == 3'h7) begin
          if (phase_q == rf_tx_pkg::PH_CMD) begin
            addr_q <= rx_byte[5:0];
            unique case (rx_byte[7:6])
              rf_tx_pkg::CMD_READ: phase_q <= rf_tx_pkg::PH_READ;
              rf_tx_pkg::CMD_WRITE: phase_q <= rf_tx_pkg::PH_WRITE;
              rf_tx_pkg::CMD_NA: phase_q <= rf_tx_pkg::PH_IGNORE;
              rf_tx_pkg::CMD_TX: phase_q <= rf_tx_pkg::PH_TX;
            endcase
          end else if (phase_q == rf_tx_pkg::PH_WRITE
              || phase_q == rf_tx_pkg::PH_READ) begin
            addr_q <= addr_q + 6'h01;
          end
        end
      end
    end
  end

  // Read data source
  always_comb begin
    if (addr_q == rf_tx_pkg::ADDR_CTRL) begin
      rd_byte = ctrl_q;
    end else if (addr_q == rf_tx_pkg::ADDR_CSUM) begin
      rd_byte = csum_q;
    end else begin
      rd_byte = mem_rdata;
    end
  end

  // Output shifter loads at the first rise of each read byte
  always_ff @(posedge clk) begin
    if (reset) begin
      out_shift_q <= 8'h00;
    end else if (ce) begin
      if (sck_rise && phase_q == rf_tx_pkg::PH_READ) begin
        if (bit_cnt_q == 3'h0) begin
          out_shift_q <= rd_byte;
        end else begin
          out_shift_q <= {out_shift_q[6:0], 1'b0};
        end
      end
    end
  end

  // Read drivers by interface mode
  always_comb begin
    sdio_o = out_shift_q[7];
    aux_test_pin_o = out_shift_q[7];
    sdio_oe = 1'b0;
    aux_test_pin_oe = 1'b0;
    if (sel_s && phase_q == rf_tx_pkg::PH_READ) begin
      unique case (ctrl_q.interface_select_field)
        rf_tx_pkg::IF_3W_SDIO: sdio_oe = 1'b1;
        rf_tx_pkg::IF_4W: aux_test_pin_oe = 1'b1;
        rf_tx_pkg::IF_3W_AUX: sdio_oe = 1'b1;
        default: sdio_oe = 1'b0;
      endcase
    end
  end

  // ****************************************************
  // Register storage
  // ****************************************************
  sfr_mem #(
    .AW(rf_tx_pkg::ADDR_W),
    .DW(rf_tx_pkg::DATA_W)
  ) u_sfr_mem (
    .clk(clk),
    .ce(ce),
    .we(wr_en),
    .waddr(addr_q),
    .wdata(rx_byte),
    .raddr(addr_q),
    .rdata(mem_rdata)
  );

  // Control register, cleared on powerdown
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= rf_tx_pkg::CTRL_RESET;
    end else if (ce) begin
      if (mode == rf_tx_pkg::MODE_POWERDOWN) begin
        ctrl_q <= rf_tx_pkg::CTRL_RESET;
      end else if (wr_en && addr_q == rf_tx_pkg::ADDR_CTRL) begin
        ctrl_q <= rx_byte;
      end
    end
  end

  // Write checksum accumulator
  always_ff @(posedge clk) begin
    if (reset) begin
      csum_q <= rf_tx_pkg::CSUM_RESET;
    end else if (ce) begin
      if (mode == rf_tx_pkg::MODE_POWERDOWN) begin
        csum_q <= rf_tx_pkg::CSUM_RESET;
      end else if (wr_en && addr_q == rf_tx_pkg::ADDR_CSUM) begin
        csum_q <= rf_tx_pkg::CSUM_RESET;
      end else if (wr_en) begin
        csum_q <= csum_q ^ rx_byte;
      end else if (byte_done && phase_q == rf_tx_pkg::PH_CMD
          && rx_byte[7:6] == rf_tx_pkg::CMD_WRITE
          && mode != rf_tx_pkg::MODE_TX_ACTIVE) begin
        csum_q <= csum_q ^ rx_byte;
      end
    end
  end

  // ****************************************************
  // Mode control
  // ****************************************************
  logic [PDW-1:0] low_cnt_q;
  logic [XW-1:0] xtal_cnt_q;
  logic xtal_ready;
  logic pd_hold_done;
  logic armed_q;
  logic pa_stop;

  assign xtal_ready = (xtal_cnt_q == XW'(XTAL_START_CYCLES));
  assign pd_hold_done = !sel_s && (low_cnt_q == PDW'(PD_HOLD_CYCLES));
  assign pa_stop = (sel_fall && !tx_cfg.pa_mode) || fail_detect;

  // Select-low timer for the powerdown hold-off
  always_ff @(posedge clk) begin
    if (reset) begin
      low_cnt_q <= '0;
    end else if (ce) begin
      if (sel_s) begin
        low_cnt_q <= '0;
      end else if (!pd_hold_done) begin
        low_cnt_q <= low_cnt_q + PDW'(1);
      end
    end
  end

  // Crystal start-up timer, restarted on wake
  always_ff @(posedge clk) begin
    if (reset) begin
      xtal_cnt_q <= '0;
    end else if (ce) begin
      if (mode == rf_tx_pkg::MODE_POWERDOWN) begin
        xtal_cnt_q <= '0;
      end else if (!xtal_ready) begin
        xtal_cnt_q <= xtal_cnt_q + XW'(1);
      end
    end
  end

  // Transmit command capture
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 1'b0;
      tx_cfg <= '0;
    end else if (ce) begin
      if (mode != rf_tx_pkg::MODE_PLL_STANDBY
          && mode != rf_tx_pkg::MODE_TX_ACTIVE) begin
        armed_q <= 1'b0;
      end else if (byte_done && phase_q == rf_tx_pkg::PH_CMD
          && rx_byte[7:6] == rf_tx_pkg::CMD_TX && tx_cmd_ok) begin
        armed_q <= 1'b1;
        tx_cfg <= rx_byte[5:0];
      end else if (armed_q && sck_rise) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Mode state machine
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= rf_tx_pkg::MODE_OSC_ACTIVE;
    end else if (ce) begin
      if (pd_hold_done || (!sel_s && ctrl_q.pd)) begin
        mode <= rf_tx_pkg::MODE_POWERDOWN;
      end else begin
        unique case (mode)
          rf_tx_pkg::MODE_POWERDOWN: begin
            if (sel_rise) begin
              mode <= rf_tx_pkg::MODE_OSC_ACTIVE;
            end
          end
          rf_tx_pkg::MODE_OSC_ACTIVE: begin
            if (ctrl_q.pllen && xtal_ready) begin
              mode <= rf_tx_pkg::MODE_PLL_STANDBY;
            end
          end
          rf_tx_pkg::MODE_PLL_STANDBY: begin
            if (!ctrl_q.pllen) begin
              mode <= rf_tx_pkg::MODE_OSC_ACTIVE;
            end else if (armed_q && sck_rise) begin
              mode <= rf_tx_pkg::MODE_TX_ACTIVE;
            end
          end
          rf_tx_pkg::MODE_TX_ACTIVE: begin
            if (pa_stop) begin
              mode <= rf_tx_pkg::MODE_PLL_STANDBY;
            end
          end
        endcase
      end
    end
  end

  assign pa_enable = (mode == rf_tx_pkg::MODE_TX_ACTIVE) && !fail_detect;

  // ****************************************************
  // Clock output divider
  // ****************************************************
  logic [CW-1:0] ck_cnt_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ck_cnt_q <= '0;
      clock_output_pin <= 1'b0;
    end else if (ce) begin
      if (mode == rf_tx_pkg::MODE_POWERDOWN || !xtal_ready) begin
        ck_cnt_q <= '0;
        clock_output_pin <= 1'b0;
      end else if (ck_cnt_q == CW'(rf_tx_pkg::CLKOUT_HALF_CYC - 1)) begin
        ck_cnt_q <= '0;
        clock_output_pin <= ~clock_output_pin;
      end else begin
        ck_cnt_q <= ck_cnt_q + CW'(1);
      end
    end
  end

  // ****************************************************
  // Transmit data path
  // ****************************************************
  logic tx_pin;
  logic edge_bit_q;
  logic [BW-1:0] br_cnt_q;
  logic half_q;
  logic sync_bit_q;
  logic src_bit;

  assign tx_pin = (ctrl_q.interface_select_field == rf_tx_pkg::IF_3W_AUX)
      ? aux_s : sdi_s;
  assign src_bit = tx_cfg.pa_mode ? edge_bit_q : tx_pin;

  // Select-fall data latch
  always_ff @(posedge clk) begin
    if (reset) begin
      edge_bit_q <= 1'b0;
    end else if (ce) begin
      if (sel_fall && mode == rf_tx_pkg::MODE_TX_ACTIVE
          && tx_cfg.pa_mode) begin
        edge_bit_q <= tx_pin;
      end
    end
  end

  // Bit-rate clock restarts when the amplifier starts
  always_ff @(posedge clk) begin
    if (reset) begin
      br_cnt_q <= '0;
      half_q <= 1'b0;
      sync_bit_q <= 1'b0;
    end else if (ce) begin
      if (mode != rf_tx_pkg::MODE_TX_ACTIVE) begin
        br_cnt_q <= '0;
        half_q <= 1'b0;
        sync_bit_q <= src_bit;
      end else if (br_cnt_q == BW'(BITRATE_HALF_CYCLES - 1)) begin
        br_cnt_q <= '0;
        half_q <= ~half_q;
        if (half_q) begin
          sync_bit_q <= src_bit;
        end
      end else begin
        br_cnt_q <= br_cnt_q + BW'(1);
      end
    end
  end

  // Modulator data, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      mod_data <= 1'b0;
    end else if (ce) begin
      if (mode != rf_tx_pkg::MODE_TX_ACTIVE) begin
        mod_data <= 1'b0;
      end else if (!tx_cfg.sync) begin
        mod_data <= src_bit;
      end else if (tx_cfg.manchester) begin
        mod_data <= sync_bit_q ^ half_q;
      end else begin
        mod_data <= sync_bit_q;
      end
    end
  end

endmodule

// *** rf_tx_pkg.sv ***
// Shared constants, layouts and types of the transmitter serial host port
package rf_tx_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // Clock output rate after the oscillator is up
  localparam int CLKOUT_HZ = 2_000_000;
  localparam int CLKOUT_HALF_CYC = CLK_HZ / (2 * CLKOUT_HZ);
  // Select-low hold-off before powerdown, least time
  localparam int PD_HOLD_NS = 8_200_000;
  localparam int PD_HOLD_CYC = (PD_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Crystal start-up, longest time
  localparam int XTAL_START_NS = 500_000;
  localparam int XTAL_START_CYC = (XTAL_START_NS * CLK_MHZ) / 1000;
  // Half bit period of the internal bit-rate clock
  localparam int BITRATE_HALF_CYC = 250;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] ADDR_CTRL = 6'h15;
  localparam logic [5:0] ADDR_CSUM = 6'h16;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CSUM_RESET = 8'h00;

  // Command codes
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_NA = 2'h2;
  localparam logic [1:0] CMD_TX = 2'h3;

  // Interface select codes
  localparam logic [1:0] IF_3W_SDIO = 2'h0;
  localparam logic [1:0] IF_4W = 2'h1;
  localparam logic [1:0] IF_3W_AUX = 2'h2;

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic [3:0] spare;
    logic pd;
    logic pllen;
    logic [1:0] interface_select_field;
  } ctrl_t;

  // Transmit flags in arrival order, first flag is the MSB
  typedef struct packed {
    logic sync;
    logic pa_mode;
    logic manchester;
    logic am_set;
    logic [1:0] channel;
  } tx_cfg_t;

  typedef enum logic [1:0] {
    MODE_POWERDOWN = 2'b00,
    MODE_OSC_ACTIVE = 2'b01,
    MODE_PLL_STANDBY = 2'b10,
    MODE_TX_ACTIVE = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_WRITE = 3'b001,
    PH_READ = 3'b010,
    PH_TX = 3'b011,
    PH_IGNORE = 3'b100
  } phase_t;

endpackage

// *** sfr_mem.sv ***
// Special-function register storage with registered read data
`timescale 1ns/1ps
module sfr_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ****************************************************
  // Write port
  // ****************************************************
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // ****************************************************
  // Registered read port
  // ****************************************************
  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// *** rf_tx_port_checker.sv ***
// Concurrent checks on the ports of the transmitter serial host port
`timescale 1ns/1ps
module rf_tx_port_checker #(
  parameter int PD_HOLD_CYCLES = rf_tx_pkg::PD_HOLD_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sel_pin,
  input wire logic sck_pin,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic aux_test_pin_oe,
  input wire logic fail_detect,
  input wire logic clock_output_pin,
  input wire rf_tx_pkg::mode_t mode,
  input wire logic pa_enable,
  input wire logic mod_data
);
  // ****************************************************
  // Helper logic
  // ****************************************************
  int low_cnt_q;
  // Cycles the select line has stayed low, saturating
  always_ff @(posedge clk) begin
    if (reset || sel_pin) begin
      low_cnt_q <= 0;
    end else if (low_cnt_q < PD_HOLD_CYCLES + 6) begin
      low_cnt_q <= low_cnt_q + 1;
    end
  end

  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || !ce);
  sequence sel_low_s;
    !sel_pin [*5];
  endsequence
  sequence tx_entry_s;
    mode == rf_tx_pkg::MODE_TX_ACTIVE && $past(mode) != mode;
  endsequence
  sequence pd_entry_s;
    mode == rf_tx_pkg::MODE_POWERDOWN && $past(mode) != mode;
  endsequence

  a_pa_follows_mode: assert property (pa_enable ==
    (mode == rf_tx_pkg::MODE_TX_ACTIVE && !fail_detect))
    else $error("amplifier enable does not follow mode");
  a_oe_exclusive: assert property (!(sdio_oe && aux_test_pin_oe))
    else $error("both data pins driven");
  a_oe_released: assert property (sel_low_s |->
    !sdio_oe && !aux_test_pin_oe)
    else $error("data pin driven with select low");
  a_out_on_rise: assert property ($changed(sdio_o) &&
    (sdio_oe || aux_test_pin_oe) |-> sck_pin)
    else $error("read data changed outside a clock rise");
  a_wake_on_select: assert property ($rose(sel_pin) &&
    mode == rf_tx_pkg::MODE_POWERDOWN |-> ##[1:6]
    mode == rf_tx_pkg::MODE_OSC_ACTIVE)
    else $error("select rise did not wake the oscillator");
  a_clkout_half: assert property ($fell(clock_output_pin) &&
    mode != rf_tx_pkg::MODE_POWERDOWN |->
    $past(clock_output_pin, 6) && !$past(clock_output_pin, 7))
    else $error("clock output half period wrong");
  a_tx_entry_cause: assert property (tx_entry_s |->
    $past(mode) == rf_tx_pkg::MODE_PLL_STANDBY && $past(sck_pin, 3))
    else $error("transmit mode entered without cause");
  a_pd_not_early: assert property (pd_entry_s |->
    low_cnt_q >= PD_HOLD_CYCLES - 1)
    else $error("powerdown entered too early");
  a_pd_due: assert property (low_cnt_q == PD_HOLD_CYCLES + 6 |->
    mode == rf_tx_pkg::MODE_POWERDOWN)
    else $error("powerdown not entered after hold-off");
  a_mod_idle_low: assert property (mode != rf_tx_pkg::MODE_TX_ACTIVE &&
    $past(mode) != rf_tx_pkg::MODE_TX_ACTIVE |-> !mod_data)
    else $error("modulator data outside transmit");
endmodule

bind rf_tx_serial_host_port rf_tx_port_checker #(
  .PD_HOLD_CYCLES(PD_HOLD_CYCLES)
) u_chk (.clk(clk), .reset(reset), .ce(ce), .sel_pin(sel_pin),
  .sck_pin(sck_pin),
  .sdio_o(sdio_o), .sdio_oe(sdio_oe), .aux_test_pin_oe(aux_test_pin_oe),
  .fail_detect(fail_detect), .clock_output_pin(clock_output_pin),
  .mode(mode), .pa_enable(pa_enable), .mod_data(mod_data));

// *** host_mcu_model.sv ***
// Host microcontroller model acting as serial master on the port pins
`timescale 1ns/1ps
module host_mcu_model (
  input wire logic clk,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic aux_o,
  input wire logic aux_oe,
  output logic sel,
  output logic sck,
  output logic sdio_i,
  output logic aux_i
);
  logic sd_h = 1'b0;
  logic aux_h = 1'b0;
  logic drv = 1'b1;
  logic w4 = 1'b0;
  logic [7:0] rx_last;
  event got;
  // Pull-downs settle a pin that nobody drives
  assign sdio_i = sdio_oe ? sdio_o : (drv & sd_h);
  assign aux_i = aux_oe ? aux_o : aux_h;
  // Pins idle low from time zero
  initial begin
    sel = 1'b0;
    sck = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit: data set at the rise, taken by the device at the fall
  task automatic xbit(input logic b, input logic rd, output logic r);
    drv = !rd;
    sd_h = b;
    sck = 1'b1;
    tick(6);
    r = w4 ? aux_i : sdio_i;
    sck = 1'b0;
    tick(6);
  endtask
  // Whole byte, most significant bit first
  task automatic xbyte(input logic [7:0] tx, input logic rd);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], rd, r);
      rx_last[i] = r;
    end
    if (rd) begin
      -> got;
    end
  endtask
  task automatic start();
    sel = 1'b1;
    tick(6);
  endtask
  // Select drops after each access so a stray clock writes nothing
  task automatic stop();
    sel = 1'b0;
    drv = 1'b1;
    tick(8);
  endtask
endmodule

// *** testbench.sv ***
// Self-checking testbench for the transmitter serial host port
`timescale 1ns/1ps
module testbench;
  localparam int PD_HOLD = 64;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic fail_detect = 1'b0;
  logic sel_pin, sck_pin, sdio_i, sdio_o, sdio_oe;
  logic aux_i, aux_o, aux_oe, clock_output_pin, pa_enable, mod_data;
  rf_tx_pkg::mode_t mode;
  rf_tx_pkg::tx_cfg_t tx_cfg;
  logic [7:0] exp_q[$];
  logic [7:0] ref_m [64];
  logic [7:0] wd [4];
  logic [7:0] csum = 8'h00;
  int num_errors = 0;
  int checked = 0;
  always #20 clk = ~clk;

  rf_tx_serial_host_port #(.PD_HOLD_CYCLES(PD_HOLD),
    .XTAL_START_CYCLES(20), .BITRATE_HALF_CYCLES(4)) i_dut (
    .clk(clk), .reset(reset), .ce(ce), .sel_pin(sel_pin),
    .sck_pin(sck_pin), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .aux_test_pin_i(aux_i), .aux_test_pin_o(aux_o),
    .aux_test_pin_oe(aux_oe), .fail_detect(fail_detect),
    .clock_output_pin(clock_output_pin), .mode(mode),
    .pa_enable(pa_enable), .mod_data(mod_data), .tx_cfg(tx_cfg));
  host_mcu_model h (.clk(clk), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .aux_o(aux_o), .aux_oe(aux_oe), .sel(sel_pin), .sck(sck_pin),
    .sdio_i(sdio_i), .aux_i(aux_i));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_mode(input rf_tx_pkg::mode_t m);
    check({6'h00, mode}, {6'h00, m});
  endtask
  // One framed access: command and address byte, then n data bytes
  task automatic acc(input logic [1:0] c, input logic [5:0] a, input int n);
    h.start();
    h.xbyte({c, a}, 1'b0);
    for (int i = 0; i < n; i++) begin
      h.xbyte(wd[i], c == rf_tx_pkg::CMD_READ);
    end
    h.stop();
  endtask
  // Write with reference update; live is low when it must be dropped
  task automatic wr(input logic [5:0] a, input int n, input logic live);
    if (live) begin
      csum ^= {rf_tx_pkg::CMD_WRITE, a};
      for (int i = 0; i < n; i++) begin
        ref_m[6'(a + i)] = wd[i];
        csum = (6'(a + i) == rf_tx_pkg::ADDR_CSUM) ? 8'h00 : csum ^ wd[i];
      end
    end
    acc(rf_tx_pkg::CMD_WRITE, a, n);
  endtask
  task automatic rd(input logic [5:0] a, input int n);
    ref_m[rf_tx_pkg::ADDR_CSUM] = csum;
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(ref_m[6'(a + i)]);
    end
    acc(rf_tx_pkg::CMD_READ, a, n);
  endtask
  // Transmit command, then one clock rise to start the amplifier
  task automatic tx(input logic [5:0] f, input rf_tx_pkg::mode_t m);
    logic r;
    h.start();
    h.xbyte({rf_tx_pkg::CMD_TX, f}, 1'b0);
    h.tick(10);
    h.xbit(1'b0, 1'b0, r);
    chk_mode(m);
  endtask

  // Each read byte is compared with the oldest note
  always @(h.got) begin
    check(h.rx_last, exp_q.pop_front());
  end

  // Main sequence
  initial begin
    logic r;
    void'($urandom(32'h7F589EFF));
    ref_m[rf_tx_pkg::ADDR_CTRL] = rf_tx_pkg::CTRL_RESET;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    chk_mode(rf_tx_pkg::MODE_OSC_ACTIVE);
    rd(rf_tx_pkg::ADDR_CTRL, 2);
    // Two single writes, checksum then holds their fold
    wd[0] = 8'h02;
    wr(6'h04, 1, 1'b1);
    wd[0] = 8'h01;
    wr(6'h05, 1, 1'b1);
    exp_q.push_back(8'h02);
    acc(rf_tx_pkg::CMD_READ, rf_tx_pkg::ADDR_CSUM, 1);
    // Burst across the top of the address space
    for (int i = 0; i < 4; i++) begin
      wd[i] = 8'($urandom);
    end
    wr(6'h3E, 4, 1'b1);
    rd(6'h3E, 4);
    rd(rf_tx_pkg::ADDR_CSUM, 1);
    wd[0] = 8'($urandom);
    wr(rf_tx_pkg::ADDR_CSUM, 1, 1'b1);
    rd(rf_tx_pkg::ADDR_CSUM, 1);
    // Half a byte cut off by select, then an unsupported command
    h.start();
    for (int i = 0; i < 4; i++) begin
      h.xbit(1'b1, 1'b0, r);
    end
    h.stop();
    wd[0] = ~ref_m[0];
    acc(rf_tx_pkg::CMD_NA, 6'h00, 1);
    rd(6'h00, 1);
    rd(rf_tx_pkg::ADDR_CSUM, 1);
    // Four-wire reads come back on the auxiliary pin
    wd[0] = {6'h00, rf_tx_pkg::IF_4W};
    wr(rf_tx_pkg::ADDR_CTRL, 1, 1'b1);
    h.w4 = 1'b1;
    rd(6'h3E, 3);
    h.w4 = 1'b0;
    tx(6'h00, rf_tx_pkg::MODE_OSC_ACTIVE);
    h.stop();
    // Standby, transmit data taken from the auxiliary pin
    wd[0] = 8'h04 | {6'h00, rf_tx_pkg::IF_3W_AUX};
    wr(rf_tx_pkg::ADDR_CTRL, 1, 1'b1);
    for (int i = 0; i < 200 && mode !== rf_tx_pkg::MODE_PLL_STANDBY; i++) begin
      h.tick(1);
    end
    tx(6'h16, rf_tx_pkg::MODE_TX_ACTIVE);
    check({2'h0, tx_cfg}, 8'h16);
    check({7'h00, pa_enable}, 8'h01);
    h.aux_h = 1'b1;
    h.stop();
    check({7'h00, mod_data}, 8'h01);
    chk_mode(rf_tx_pkg::MODE_TX_ACTIVE);
    wd[0] = ~ref_m[0];
    wr(6'h00, 1, 1'b0);
    fail_detect = 1'b1;
    h.tick(1);
    check({7'h00, pa_enable}, 8'h00);
    h.tick(3);
    fail_detect = 1'b0;
    chk_mode(rf_tx_pkg::MODE_PLL_STANDBY);
    rd(6'h00, 1);
    rd(rf_tx_pkg::ADDR_CSUM, 1);
    // Every channel code; select fall now stops the amplifier
    for (int c = 0; c < 4; c++) begin
      tx({4'hA, 2'(c)}, rf_tx_pkg::MODE_TX_ACTIVE);
      check({2'h0, tx_cfg}, {2'h0, 4'hA, 2'(c)});
      h.stop();
      chk_mode(rf_tx_pkg::MODE_PLL_STANDBY);
    end
    // Long select low falls into powerdown, which clears control and checksum registers
    h.tick(PD_HOLD + 8);
    chk_mode(rf_tx_pkg::MODE_POWERDOWN);
    // Clock enable low freezes the port, so a select rise goes unseen
    ce = 1'b0;
    h.start();
    h.tick(2 + $urandom % 8);
    chk_mode(rf_tx_pkg::MODE_POWERDOWN);
    ce = 1'b1;
    ref_m[rf_tx_pkg::ADDR_CTRL] = rf_tx_pkg::CTRL_RESET;
    csum = rf_tx_pkg::CSUM_RESET;
    rd(rf_tx_pkg::ADDR_CTRL, 2);
    chk_mode(rf_tx_pkg::MODE_OSC_ACTIVE);
    for (int i = 0; i < 200 && clock_output_pin !== 1'b1; i++) begin
      h.tick(1);
    end
    check({7'h00, clock_output_pin}, 8'h01);
    report_and_stop();
  end

  // Watchdog against a hung handshake
  initial begin
    #1_200_000;
    num_errors++;
    report_and_stop();
  end
endmodule
